// ### verilog/obf_pkg.sv
// Package with register map, field positions and reset values of the one-bit FIFO
package obf_pkg;
   // Register word offsets (byte addresses)
   localparam logic [3:0] OFS_CTRL   = 4'h0;
   localparam logic [3:0] OFS_STATUS = 4'h4;
   localparam logic [3:0] OFS_MASK   = 4'h8;
   localparam logic [3:0] OFS_LEVEL  = 4'hc;
   // Control fields
   localparam int CTRL_STROBED_BIT = 0;
   localparam int CTRL_FALLING_BIT = 1;
   // Status / mask fields
   localparam int ST_WR_REFUSED = 0;
   localparam int ST_RD_REFUSED = 1;
   localparam int ST_HALF_RISE  = 2;
   localparam int ST_WIDTH      = 3;
   // Values after reset
   localparam logic [1:0]        CTRL_RST   = 2'h0;
   localparam logic [ST_WIDTH-1:0] STATUS_RST = 3'h0;
   localparam logic [ST_WIDTH-1:0] MASK_RST   = 3'h0;
   localparam logic              IR_RST     = 1'h1;
   localparam logic              OR_RST     = 1'h0;
   // Default geometry
   localparam int DEPTH_DEF      = 64;
   localparam int AFE_OFFSET_DEF = 8;
endpackage : obf_pkg

// ### verilog/obf_fifo.sv
// One-bit FIFO with two link clocks sampled by the core clock, flags and a small register port
// Contract
// - Bits leave in exactly the order they were accepted.
// - Storage and output are one bit per word.
// - Write and read clocks are independent; no phase or rate relation assumed.
// - Strobed mode stores one bit on each active write edge; polarity configurable.
// - Strobed mode shows full when no room remains; writer must not write then.
// - Strobed mode pops one bit per active read edge and shows empty.
// - Clocked mode: free-running clocks; transfer only on edges with enable high.
// - Input ready changes only on write clock edges.
// - Output ready changes only on read clock edges.
// - Half full and almost full/empty flags change only on write clock edges.
`timescale 1ns/100ps
module obf_fifo #(
   parameter int DEPTH      = obf_pkg::DEPTH_DEF,
   parameter int AFE_OFFSET = obf_pkg::AFE_OFFSET_DEF
) (
   input  wire logic        core_clk_i,
   input  wire logic        reset_i,
   input  wire logic        write_clock_i,
   input  wire logic        write_enable_i,
   input  wire logic        write_data_i,
   input  wire logic        read_clock_i,
   input  wire logic        read_enable_i,
   output logic             read_data_o,
   output logic             input_ready_o,
   output logic             output_ready_o,
   output logic             half_full_flag_o,
   output logic             almost_full_empty_flag_o,
   output logic             full_o,
   output logic             empty_o,
   input  wire logic [3:0]  reg_addr_i,
   input  wire logic [31:0] reg_wdata_i,
   input  wire logic        reg_write_i,
   input  wire logic        reg_read_i,
   output logic [31:0]      reg_rdata_o,
   output logic             irq_o
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
   localparam logic [CW-1:0] HALF_C  = CW'(DEPTH / 2);
   localparam logic [CW-1:0] AFE_C   = CW'(AFE_OFFSET);
   localparam logic [PW-1:0] LAST_C  = PW'(DEPTH - 1);

   // Two-stage synchronisers; stage three only serves the edge detectors
   logic [4:0] s1_ff, s2_ff;
   logic       wclk_d_ff, rclk_d_ff;
   logic [1:0] ctrl_ff;
   logic [DEPTH-1:0] mem_ff;
   logic [PW-1:0]    wr_ptr_ff, rd_ptr_ff;
   logic [CW-1:0]    count_ff, nxt_count;
   logic       ir_ff, or_ff, hf_ff, afe_ff, full_ff, empty_ff, rdata_ff;
   logic [obf_pkg::ST_WIDTH-1:0] status_ff, mask_ff, nxt_status;
   logic [31:0] rdata_bus_ff;
   logic       wclk_s, rclk_s, wen_s, wdat_s, ren_s;
   logic       strobed, w_edge, r_edge, w_rise, w_fall, r_rise, r_fall;
   logic       do_write, do_read, wr_refused, rd_refused;

   // All five link pin inputs pass two flops before use; clocks are only slow inputs here
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         s1_ff <= 5'h00;
         s2_ff <= 5'h00;
      end else begin
         s1_ff <= {read_enable_i, read_clock_i, write_data_i, write_enable_i, write_clock_i};
         s2_ff <= s1_ff;
      end
   end
   assign {ren_s, rclk_s, wdat_s, wen_s, wclk_s} = s2_ff;

   // Edge detection on the synchronised clocks; link clocks must be slower than a quarter of core
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         wclk_d_ff <= 1'h0;
         rclk_d_ff <= 1'h0;
      end else begin
         wclk_d_ff <= wclk_s;
         rclk_d_ff <= rclk_s;
      end
   end
   assign w_rise  = wclk_s & ~wclk_d_ff;
   assign w_fall  = ~wclk_s & wclk_d_ff;
   assign r_rise  = rclk_s & ~rclk_d_ff;
   assign r_fall  = ~rclk_s & rclk_d_ff;
   assign strobed = ctrl_ff[obf_pkg::CTRL_STROBED_BIT];
   // Polarity choice only applies in strobed mode; clocked mode always uses rising edges
   assign w_edge = (strobed && ctrl_ff[obf_pkg::CTRL_FALLING_BIT]) ? w_fall : w_rise;
   assign r_edge = (strobed && ctrl_ff[obf_pkg::CTRL_FALLING_BIT]) ? r_fall : r_rise;

   // Transfer decisions per mode
   always_comb begin
      do_write   = 1'b0;
      do_read    = 1'b0;
      wr_refused = 1'b0;
      rd_refused = 1'b0;
      if (strobed) begin
         do_write   = w_edge && (count_ff != DEPTH_C);
         wr_refused = w_edge && (count_ff == DEPTH_C);
         do_read    = r_edge && (count_ff != '0);
         rd_refused = r_edge && (count_ff == '0);
      end else begin
         do_write   = w_edge && wen_s && ir_ff;
         wr_refused = w_edge && wen_s && !ir_ff;
         do_read    = r_edge && ren_s && or_ff;
         rd_refused = r_edge && ren_s && !or_ff;
      end
   end

   // Occupancy; simultaneous push and pop cancel
   always_comb begin
      nxt_count = count_ff;
      if (do_write && !do_read) begin
         nxt_count = count_ff + CW'(1);
      end else if (do_read && !do_write) begin
         nxt_count = count_ff - CW'(1);
      end
   end

   // Bit storage written at the write pointer; no reset needed for data
   always_ff @(posedge core_clk_i) begin
      if (do_write) begin
         mem_ff[wr_ptr_ff] <= wdat_s;
      end
   end

   // Pointers advance only on accepted transfers, keeping strict order
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         count_ff  <= '0;
      end else begin
         if (do_write) begin
            wr_ptr_ff <= (wr_ptr_ff == LAST_C) ? '0 : wr_ptr_ff + PW'(1);
         end
         if (do_read) begin
            rd_ptr_ff <= (rd_ptr_ff == LAST_C) ? '0 : rd_ptr_ff + PW'(1);
         end
         count_ff <= nxt_count;
      end
   end

   // Output bit is the oldest entry, held until the next pop
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         rdata_ff <= 1'h0;
      end else if (do_read) begin
         rdata_ff <= mem_ff[rd_ptr_ff];
      end
   end

   // Write-side flags refresh only on write edges; reads between edges leave them
   // conservatively stale, which can never permit an overflow
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         ir_ff  <= obf_pkg::IR_RST;
         hf_ff  <= 1'h0;
         afe_ff <= 1'h1;
      end else if (w_edge) begin
         ir_ff  <= (nxt_count < DEPTH_C);
         hf_ff  <= (nxt_count > HALF_C);
         afe_ff <= (nxt_count <= AFE_C) || (nxt_count >= DEPTH_C - AFE_C);
      end
   end

   // Read-side flag refreshes only on read edges; a stale low only delays a read
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         or_ff <= obf_pkg::OR_RST;
      end else if (r_edge) begin
         or_ff <= (nxt_count != '0);
      end
   end

   // Strobed-mode full and empty follow the occupancy every core cycle
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         full_ff  <= 1'h0;
         empty_ff <= 1'h1;
      end else begin
         full_ff  <= (nxt_count == DEPTH_C);
         empty_ff <= (nxt_count == '0);
      end
   end

   // Control and mask registers
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         ctrl_ff <= obf_pkg::CTRL_RST;
         mask_ff <= obf_pkg::MASK_RST;
      end else if (reg_write_i) begin
         if (reg_addr_i == obf_pkg::OFS_CTRL) begin
            ctrl_ff <= reg_wdata_i[1:0];
         end
         if (reg_addr_i == obf_pkg::OFS_MASK) begin
            mask_ff <= reg_wdata_i[obf_pkg::ST_WIDTH-1:0];
         end
      end
   end

   // Sticky status, cleared by a read; a new event in the clearing cycle survives
   always_comb begin
      nxt_status = status_ff;
      if (reg_read_i && reg_addr_i == obf_pkg::OFS_STATUS) begin
         nxt_status = '0;
      end
      nxt_status[obf_pkg::ST_WR_REFUSED] = nxt_status[obf_pkg::ST_WR_REFUSED] | wr_refused;
      nxt_status[obf_pkg::ST_RD_REFUSED] = nxt_status[obf_pkg::ST_RD_REFUSED] | rd_refused;
      nxt_status[obf_pkg::ST_HALF_RISE]  = nxt_status[obf_pkg::ST_HALF_RISE]
                                           | (w_edge && !hf_ff && (nxt_count > HALF_C));
   end
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         status_ff <= obf_pkg::STATUS_RST;
      end else begin
         status_ff <= nxt_status;
      end
   end

   // Read data one cycle after the strobe; unmapped addresses read zero
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         rdata_bus_ff <= 32'h0000_0000;
      end else if (reg_read_i) begin
         case (reg_addr_i)
            obf_pkg::OFS_CTRL:   rdata_bus_ff <= {30'h0000_0000, ctrl_ff};
            obf_pkg::OFS_STATUS: rdata_bus_ff <= {29'h0000_0000, status_ff};
            obf_pkg::OFS_MASK:   rdata_bus_ff <= {29'h0000_0000, mask_ff};
            obf_pkg::OFS_LEVEL:  rdata_bus_ff <= 32'(count_ff);
            default:             rdata_bus_ff <= 32'h0000_0000;
         endcase
      end else begin
         rdata_bus_ff <= 32'h0000_0000;
      end
   end

   assign read_data_o              = rdata_ff;
   assign input_ready_o            = ir_ff;
   assign output_ready_o           = or_ff;
   assign half_full_flag_o         = hf_ff;
   assign almost_full_empty_flag_o = afe_ff;
   assign full_o                   = full_ff;
   assign empty_o                  = empty_ff;
   assign reg_rdata_o              = rdata_bus_ff;
   assign irq_o                    = |(status_ff & mask_ff);

   // Checks on the block's own behaviour
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (reset_i);

   chk_occupancy_bound: assert property (count_ff <= DEPTH_C)
      else $error("occupancy beyond depth");
   chk_ir_write_edge: assert property (!$past(w_edge) |-> $stable(ir_ff))
      else $error("input ready moved without write edge");
   chk_or_read_edge: assert property (!$past(r_edge) |-> $stable(or_ff))
      else $error("output ready moved without read edge");
   chk_flags_write_edge: assert property (!$past(w_edge) |-> $stable(hf_ff) && $stable(afe_ff))
      else $error("write-side flags moved without write edge");
   chk_pop_oldest: assert property (do_read |=> rdata_ff == $past(mem_ff[rd_ptr_ff]))
      else $error("read bit is not the oldest entry");
   chk_refused_write: assert property (wr_refused |=> $stable(wr_ptr_ff) && $stable(mem_ff))
      else $error("refused write changed storage");
   chk_refused_read: assert property (rd_refused |=> $stable(rd_ptr_ff) && $stable(rdata_ff))
      else $error("refused read changed pointer");
   chk_full_no_push: assert property (strobed && count_ff == DEPTH_C |-> !do_write)
      else $error("write accepted while full");
   chk_strobe_push: assert property (strobed && w_edge && count_ff < DEPTH_C && !do_read
                                     |=> count_ff == $past(count_ff) + CW'(1))
      else $error("strobed write edge did not store a bit");
   chk_empty_flag: assert property (count_ff == '0 |=> empty_ff || $past(do_write))
      else $error("empty not shown with nothing stored");
   chk_half_thresh: assert property (w_edge && nxt_count > HALF_C |=> hf_ff)
      else $error("half full missing above half depth");
   chk_clocked_enable: assert property (!strobed && !wen_s |-> !do_write)
      else $error("write without enable in clocked mode");

   // Ready flags may lag behind the occupancy, but only ever on the safe side
   chk_ir_has_room: assert property (ir_ff |-> count_ff < DEPTH_C)
      else $error("input ready shown with no room left");
   chk_or_has_data: assert property (or_ff |-> count_ff != '0)
      else $error("output ready shown with nothing stored");
   chk_full_flag: assert property (count_ff == DEPTH_C |=> full_ff || $past(do_read))
      else $error("full not shown with storage full");
   chk_strobe_pop: assert property (strobed && r_edge && count_ff != '0 && !do_write
                                    |=> count_ff == $past(count_ff) - CW'(1))
      else $error("strobed read edge did not remove a bit");
   chk_refused_sticky: assert property (wr_refused |=> status_ff[obf_pkg::ST_WR_REFUSED])
      else $error("refused write not recorded in status");
   chk_clocked_read_en: assert property (!strobed && !ren_s |-> !do_read)
      else $error("read without enable in clocked mode");
   chk_afe_low_end: assert property (w_edge && nxt_count <= AFE_C |=> afe_ff)
      else $error("almost empty missing near the empty end");

   cov_fill_full: cover property (count_ff == DEPTH_C);
   cov_push_pop_same: cover property (do_write && do_read);
   cov_refused_irq: cover property (wr_refused ##[1:20] irq_o);
   cov_strobed_falling: cover property (strobed && ctrl_ff[obf_pkg::CTRL_FALLING_BIT] && do_read);
   cov_afe_near_full: cover property (afe_ff && hf_ff);
endmodule // obf_fifo

// ### testbench/obf_link_model.sv
// Behavioural link-side writer and reader for the one-bit FIFO
`timescale 1ns/100ps
module obf_link_model (
   input  wire logic core_clk_i,
   output logic      write_clock_o,
   output logic      write_enable_o,
   output logic      write_data_o,
   output logic      read_clock_o,
   output logic      read_enable_o,
   input  wire logic read_data_i
);
   // Clocks rest low so no stray edge reaches the synchronisers
   initial begin
      write_clock_o  = 1'b0;
      write_enable_o = 1'b0;
      write_data_o   = 1'b0;
      read_clock_o   = 1'b0;
      read_enable_o  = 1'b0;
   end
   // One 160 ns write period of 16 core cycles; back-to-back calls keep the clock running
   task automatic wr(input logic d, input logic en);
      write_data_o   <= d;
      write_enable_o <= en;
      repeat (4) @(posedge core_clk_i);
      write_clock_o  <= 1'b1;
      repeat (6) @(posedge core_clk_i);
      write_clock_o  <= 1'b0;
      repeat (3) @(posedge core_clk_i);
      write_enable_o <= 1'b0;
      write_data_o   <= ~d; // Released line shows the inverse, not a stale copy
      repeat (3) @(posedge core_clk_i);
   endtask
   // One 160 ns read period; bit taken late so a falling-edge pop has landed
   task automatic rd(input logic en, output logic d);
      read_enable_o <= en;
      repeat (4) @(posedge core_clk_i);
      read_clock_o  <= 1'b1;
      repeat (6) @(posedge core_clk_i);
      read_clock_o  <= 1'b0;
      repeat (3) @(posedge core_clk_i);
      read_enable_o <= 1'b0;
      repeat (3) @(posedge core_clk_i);
      d = read_data_i;
   endtask
endmodule // obf_link_model

// ### testbench/obf_fifo_tb.sv
// Self-checking bench: queue model of the one-bit FIFO against the design
`timescale 1ns/100ps
module obf_fifo_tb;
   localparam int DEPTH = 8;
   localparam int AFE   = 2;
   logic        core_clk, reset, wclk, wen, wdat, rclk, ren, rdat;
   logic        ir, orr, hf, afe, full, empty, irq, reg_write, reg_read;
   logic [3:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata, st, seed;
   int          err_count, n_checks;
   bit          ir_m, or_m;
   bit          q[$];

   obf_fifo #(.DEPTH(DEPTH), .AFE_OFFSET(AFE)) i_obf_fifo (
      .core_clk_i(core_clk), .reset_i(reset), .write_clock_i(wclk), .write_enable_i(wen),
      .write_data_i(wdat), .read_clock_i(rclk), .read_enable_i(ren), .read_data_o(rdat),
      .input_ready_o(ir), .output_ready_o(orr), .half_full_flag_o(hf),
      .almost_full_empty_flag_o(afe), .full_o(full), .empty_o(empty), .reg_addr_i(reg_addr),
      .reg_wdata_i(reg_wdata), .reg_write_i(reg_write), .reg_read_i(reg_read),
      .reg_rdata_o(reg_rdata), .irq_o(irq));
   obf_link_model i_obf_link_model (
      .core_clk_i(core_clk), .write_clock_o(wclk), .write_enable_o(wen), .write_data_o(wdat),
      .read_clock_o(rclk), .read_enable_o(ren), .read_data_i(rdat));

   // 100 MHz core clock
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   function automatic logic rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[0];
   endfunction

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // Register bus: strobes last one cycle, read data stands only in the next cycle
   task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge core_clk);
      reg_write <= 1'b0;
   endtask
   task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge core_clk);
      reg_read <= 1'b0;
      #1 d = reg_rdata;
   endtask

   // One write edge; the model books it mid-period, just after the design has taken a rising
   // edge, so concurrent reads and writes are counted in the same order on both sides
   task automatic do_wr(input logic d, input logic en, input bit sm);
      int n;
      n = 0;
      fork
         i_obf_link_model.wr(d, en);
         begin
            repeat (8) @(posedge core_clk);
            if (sm ? q.size() < DEPTH : (en && ir_m)) q.push_back(d);
            n = q.size();
            ir_m = n < DEPTH;
         end
      join
      chk("full", 32'(q.size() == DEPTH), 32'(full));
      if (!sm) begin
         chk("input_ready", 32'(ir_m), 32'(ir));
         chk("half_full", 32'(n > DEPTH / 2), 32'(hf));
         chk("almost_full_empty", 32'(n <= AFE || n >= DEPTH - AFE), 32'(afe));
      end
   endtask

   // One read edge; popped bits must come out oldest first
   task automatic do_rd(input logic en, input bit sm);
      logic d;
      bit   pop;
      bit   exp;
      pop = 1'b0;
      exp = 1'b0;
      fork
         i_obf_link_model.rd(en, d);
         begin
            repeat (8) @(posedge core_clk);
            pop = sm ? q.size() > 0 : (en && or_m);
            if (pop) exp = q.pop_front();
            or_m = q.size() > 0;
         end
      join
      if (pop) begin
         chk("read_data", 32'(exp), 32'(d));
      end
      chk("empty", 32'(q.size() == 0), 32'(empty));
      if (!sm) chk("output_ready", 32'(or_m), 32'(orr));
   endtask

   // A hang ends the run as a mismatch
   initial begin
      #200000;
      err_count++;
      wrap_up();
   end

   initial begin
      seed = 32'hd173dda9;
      reset = 1'b1;
      reg_addr = 4'h0;
      reg_wdata = 32'h0;
      reg_write = 1'b0;
      reg_read = 1'b0;
      ir_m = 1'b1;
      or_m = 1'b0;
      repeat (20) @(posedge core_clk);
      reset <= 1'b0;
      repeat (3) @(posedge core_clk);
      chk("reset_flags", 32'h94, 32'({ir, orr, hf, afe, full, empty, irq, rdat}));
      reg_rd(obf_pkg::OFS_CTRL, st);
      chk("ctrl_reset", 32'(obf_pkg::CTRL_RST), st);
      reg_rd(obf_pkg::OFS_STATUS, st);
      chk("status_reset", 32'(obf_pkg::STATUS_RST), st);
      reg_rd(obf_pkg::OFS_MASK, st);
      chk("mask_reset", 32'(obf_pkg::MASK_RST), st);
      reg_wr(4'h2, 32'hffffffff); // Unmapped: ignored, reads zero
      reg_rd(4'h2, st);
      chk("unmapped", 32'h0, st);
      reg_wr(obf_pkg::OFS_LEVEL, 32'h5); // Level is read only
      reg_rd(obf_pkg::OFS_LEVEL, st);
      chk("level_ro", 32'h0, st);
      reg_wr(obf_pkg::OFS_MASK, 32'h7);
      // Clocked fill past full: last write refused
      repeat (DEPTH + 1) do_wr(rnd(), 1'b1, 1'b0);
      reg_rd(obf_pkg::OFS_MASK, st);
      chk("irq_wr_refused", 32'h1, 32'(irq));
      reg_rd(obf_pkg::OFS_STATUS, st);
      chk("status_fill", (32'h1 << obf_pkg::ST_WR_REFUSED) | (32'h1 << obf_pkg::ST_HALF_RISE), st);
      reg_rd(obf_pkg::OFS_STATUS, st);
      chk("status_cleared", 32'h0, st);
      chk("irq_cleared", 32'h0, 32'(irq));
      reg_rd(obf_pkg::OFS_LEVEL, st);
      chk("level_full", 32'(DEPTH), st);
      // Output ready is still low from reset: this read is refused
      do_rd(1'b1, 1'b0);
      reg_wr(obf_pkg::OFS_MASK, 32'h0);
      reg_rd(obf_pkg::OFS_MASK, st);
      chk("irq_masked", 32'h0, 32'(irq));
      reg_wr(obf_pkg::OFS_MASK, 32'h7);
      reg_rd(obf_pkg::OFS_MASK, st);
      chk("irq_unmasked", 32'h1, 32'(irq));
      reg_rd(obf_pkg::OFS_STATUS, st);
      chk("status_rd_refused", 32'h1 << obf_pkg::ST_RD_REFUSED, st);
      repeat (4) do_rd(rnd(), 1'b0);
      do_wr(1'b0, 1'b0, 1'b0);
      // Both sides at once, read periods starting three core cycles after the write periods
      fork
         repeat (24) do_wr(rnd(), 1'b1, 1'b0);
         begin
            repeat (3) @(posedge core_clk);
            repeat (24) do_rd(1'b1, 1'b0);
         end
      join
      repeat (DEPTH + 1) do_rd(1'b1, 1'b0);
      reg_rd(obf_pkg::OFS_STATUS, st);
      chk("status_drain", 32'h1 << obf_pkg::ST_RD_REFUSED, st & (32'h1 << obf_pkg::ST_RD_REFUSED));
      // Strobed mode, rising then falling active edge; writer overruns on purpose
      for (int pol = 0; pol < 2; pol++) begin
         reg_wr(obf_pkg::OFS_CTRL, 32'h1 | 32'(pol << 1));
         reg_rd(obf_pkg::OFS_CTRL, st);
         chk("ctrl_mode", 32'h1 | 32'(pol << 1), st);
         repeat (DEPTH + 1) do_wr(rnd(), rnd(), 1'b1);
         repeat (DEPTH + 1) do_rd(rnd(), 1'b1);
         reg_rd(obf_pkg::OFS_STATUS, st);
         chk("status_strobed", 32'h3, st & 32'h3);
      end
      wrap_up();
   end
endmodule // obf_fifo_tb
